//--- hw/nss_pkg.sv
package nss_pkg;

   // ****************************************
   // stream layout
   // ****************************************
   localparam int STREAM_BITS      = 32;
   localparam int PORT_COUNT       = 8;
   localparam int PRESENCE_LSB     = 0;
   localparam int WAKE_BIT         = 4;
   localparam int WARN_BIT         = 5;
   localparam int CRIT_BIT         = 6;
   localparam int FAN_BIT          = 7;
   localparam int PORT_BASE_BIT    = 8;
   localparam int PORT_STRIDE      = 3;
   localparam int SPEED_FULL_OFS   = 0;
   localparam int SPEED_REDUCED_OFS = 1;
   localparam int TRAFFIC_OFS      = 2;
   localparam int STAGE_BITS       = 8;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [31:0] STREAM_RESET = 32'hffffff7f;
   localparam logic        PIN_IDLE     = 1'b1;

   // ****************************************
   // temperature and timing
   // ****************************************
   localparam int          TEMP_BITS        = 8;
   localparam logic [7:0]  FAN_HYST_DEG_C   = 8'h05;
   localparam int          CLK_HZ           = 10_000_000;
   localparam int          BLINK_HALF_MS    = 100;
   localparam int          BLINK_HALF_CYCLES = (CLK_HZ / 1000) * BLINK_HALF_MS;

   // ****************************************
   // interrupt status bits
   // ****************************************
   localparam int IRQ_BITS      = 4;
   localparam int IRQ_CAPTURE   = 0;
   localparam int IRQ_WARN      = 1;
   localparam int IRQ_CRIT      = 2;
   localparam int IRQ_FAN       = 3;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] ADDR_CTRL       = 4'h0;
   localparam logic [3:0] ADDR_FAN_SET    = 4'h1;
   localparam logic [3:0] ADDR_TEMP       = 4'h2;
   localparam logic [3:0] ADDR_IDENT      = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
   localparam logic [3:0] ADDR_IRQ_MASK   = 4'h5;
   localparam logic [3:0] ADDR_SNAPSHOT   = 4'h6;
   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] FAN_SET_RESET   = 8'h55;

endpackage

//--- hw/nss_scan_chain.sv
`timescale 1ns/10ps
`default_nettype none

module nss_scan_chain
   import nss_pkg::*;
#(
   parameter int PORTS        = 8,
   parameter int STAGES       = 4,
   parameter int BLINK_CYCLES = BLINK_HALF_CYCLES
) (
   // clock and reset
   input  wire  logic                    clk,
   input  wire  logic                    reset_n,
   input  wire  logic                    clk_en,
   // scan link from the baseboard
   input  wire  logic                    scan_clk,
   input  wire  logic                    capture_strobe_n,
   output var   logic                    scan_data_out,
   // card status pins
   input  wire  logic [3:0]              card_presence_straps_n,
   input  wire  logic                    wake_n,
   input  wire  logic                    temp_warn_any,
   input  wire  logic                    thermal_critical_any,
   input  wire  logic [TEMP_BITS-1:0]    fan_temp,
   // per-port link state
   input  wire  logic [PORTS-1:0]        port_link_up,
   input  wire  logic [PORTS-1:0]        port_at_max_speed,
   input  wire  logic [PORTS-1:0]        port_traffic,
   // register port
   input  wire  logic [3:0]              reg_addr,
   input  wire  logic [31:0]             reg_wdata,
   input  wire  logic                    reg_write,
   input  wire  logic                    reg_read,
   output var   logic [31:0]             reg_rdata,
   // interrupt
   output var   logic                    irq
);
   import nss_pkg::*;

   localparam int ASYNC_W = 4 + 1 + 2 + TEMP_BITS + 3 * PORTS + 2;
   localparam int LAST_BIT = STAGE_BITS * STAGES;
   // synchroniser reset matches idle pins: clock, strobe, wake and straps high, the rest low,
   // so no false edge, event or fan request follows reset
   localparam logic [ASYNC_W-1:0] SYNC_IDLE = {2'h3, {(3 * PORTS + TEMP_BITS + 2){1'b0}},
                                               1'b1, 4'hf};

   // bit position of one indication of one port within the stream
   function automatic int port_bit(input int port, input int ofs);
      return PORT_BASE_BIT + PORT_STRIDE * port + ofs;
   endfunction

   // a level that is high now and was low one sample ago
   function automatic logic rose(input logic lvl, input logic prev);
      return lvl & ~prev;
   endfunction

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [ASYNC_W-1:0] async_in;
   logic [ASYNC_W-1:0] sync_a_reg;
   logic [ASYNC_W-1:0] sync_b_reg;

   assign async_in = {scan_clk, capture_strobe_n, port_traffic, port_at_max_speed,
                      port_link_up, fan_temp, thermal_critical_any, temp_warn_any,
                      wake_n, card_presence_straps_n};

   // while the clock enable is low the pins are not sampled, so link pulses that end before it returns are lost
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sync_a_reg <= SYNC_IDLE;
         sync_b_reg <= SYNC_IDLE;
      end else if (clk_en) begin
         sync_a_reg <= async_in;
         sync_b_reg <= sync_a_reg;
      end
   end

   logic [3:0]           s_straps_n;
   logic                 s_wake_n;
   logic                 s_warn;
   logic                 s_crit;
   logic [TEMP_BITS-1:0] s_temp;
   logic [PORTS-1:0]     s_up;
   logic [PORTS-1:0]     s_max;
   logic [PORTS-1:0]     s_traffic;
   logic                 s_load_n;
   logic                 s_sclk;

   assign {s_sclk, s_load_n, s_traffic, s_max, s_up, s_temp, s_crit, s_warn,
           s_wake_n, s_straps_n} = sync_b_reg;

   // ****************************************
   // control registers
   // ****************************************
   logic [7:0]            ctrl_reg;
   logic [TEMP_BITS-1:0]  fan_set_reg;
   logic [PORTS-1:0]      ident_reg;
   logic [IRQ_BITS-1:0]   irq_status_reg;
   logic [IRQ_BITS-1:0]   irq_mask_reg;

   // ****************************************
   // fan request with hysteresis
   // ****************************************
   logic                 fan_reg;
   logic [TEMP_BITS:0]   fan_clear_level;

   // a set point below the hysteresis borrows; the request then never clears
   assign fan_clear_level = {1'b0, fan_set_reg} - {1'b0, FAN_HYST_DEG_C};

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         fan_reg <= 1'b0;
      end else if (clk_en) begin
         if (s_temp > fan_set_reg) begin
            fan_reg <= 1'b1;
         end else if (!fan_clear_level[TEMP_BITS]
                      && {1'b0, s_temp} <= fan_clear_level) begin
            fan_reg <= 1'b0;
         end
      end
   end

   // ****************************************
   // blink timebase
   // ****************************************
   // the 24-bit counter limits the half period to 2**24 cycles
   logic [23:0] blink_cnt_reg;
   logic        blink_phase_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         blink_cnt_reg   <= '0;
         blink_phase_reg <= 1'b0;
      end else if (clk_en) begin
         // equal phases keep the duty cycle at one half
         if (blink_cnt_reg == 24'(BLINK_CYCLES - 1)) begin
            blink_cnt_reg   <= '0;
            blink_phase_reg <= ~blink_phase_reg;
         end else begin
            blink_cnt_reg <= blink_cnt_reg + 24'h000001;
         end
      end
   end

   // ****************************************
   // per-port indications
   // ****************************************
   logic [PORTS-1:0] full_n;
   logic [PORTS-1:0] reduced_n;
   logic [PORTS-1:0] traffic_n;

   for (genvar p = 0; p < PORTS; p++) begin : g_port
      // identify blink takes the full-speed bit over whatever the link does
      assign full_n[p] =
         ident_reg[p] ? blink_phase_reg : ~(s_up[p] & s_max[p]);
      assign reduced_n[p] = ~(s_up[p] & ~s_max[p]);
      // an idle link lights steadily; traffic blinks it on the shared timebase
      assign traffic_n[p] = ~s_up[p] | (s_traffic[p] & blink_phase_reg);
   end

   // ****************************************
   // parallel status image
   // ****************************************
   logic [STREAM_BITS-1:0] image;

   always_comb begin
      image = STREAM_RESET;
      image[PRESENCE_LSB +: 4] = s_straps_n;
      image[WAKE_BIT] = s_wake_n;
      image[WARN_BIT] = ~s_warn;
      image[CRIT_BIT] = ~s_crit;
      image[FAN_BIT]  = fan_reg;
      for (int p = 0; p < PORTS; p++) begin
         image[port_bit(p, SPEED_FULL_OFS)]    = full_n[p];
         image[port_bit(p, SPEED_REDUCED_OFS)] = reduced_n[p];
         image[port_bit(p, TRAFFIC_OFS)]       = traffic_n[p];
      end
      for (int b = 0; b < STREAM_BITS; b++) begin
         if (b >= LAST_BIT) begin
            image[b] = 1'b1;
         end
      end
   end

   // ****************************************
   // shift chain
   // ****************************************
   logic [STREAM_BITS-1:0] shift_reg;
   logic                   sclk_prev_reg;
   logic                   sclk_rise;
   logic                   capture_evt;

   assign sclk_rise   = rose(s_sclk, sclk_prev_reg);
   assign capture_evt = ~s_load_n;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         // the scan clock idles high, so a low value here would fake a rise
         sclk_prev_reg <= PIN_IDLE;
         shift_reg     <= STREAM_RESET;
         scan_data_out <= PIN_IDLE;
      end else if (clk_en) begin
         sclk_prev_reg <= s_sclk;
         // load wins: scan edges while the strobe is low are ignored
         if (capture_evt) begin
            shift_reg     <= image;
            scan_data_out <= image[0];
         end else if (sclk_rise) begin
            // ones shift in behind the last bit, as a tied-high serial input
            shift_reg     <= {1'b1, shift_reg[STREAM_BITS-1:1]};
            scan_data_out <= shift_reg[1];
         end
      end
   end

   // ****************************************
   // register access and interrupts
   // ****************************************
   logic [IRQ_BITS-1:0] irq_events;
   logic                load_prev_reg;
   logic                warn_prev_reg;
   logic                crit_prev_reg;
   logic                fan_prev_reg;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         load_prev_reg <= 1'b1;
         warn_prev_reg <= 1'b0;
         crit_prev_reg <= 1'b0;
         fan_prev_reg  <= 1'b0;
      end else if (clk_en) begin
         load_prev_reg <= s_load_n;
         warn_prev_reg <= s_warn;
         crit_prev_reg <= s_crit;
         fan_prev_reg  <= fan_reg;
      end
   end

   always_comb begin
      irq_events              = '0;
      irq_events[IRQ_CAPTURE] = load_prev_reg & ~s_load_n;
      irq_events[IRQ_WARN]    = rose(s_warn, warn_prev_reg);
      irq_events[IRQ_CRIT]    = rose(s_crit, crit_prev_reg);
      irq_events[IRQ_FAN]     = rose(fan_reg, fan_prev_reg);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl_reg     <= CTRL_RESET;
         fan_set_reg  <= FAN_SET_RESET;
         ident_reg    <= '0;
         irq_mask_reg <= '0;
      end else if (clk_en && reg_write) begin
         unique case (reg_addr)
            ADDR_CTRL:     ctrl_reg     <= reg_wdata[7:0];
            ADDR_FAN_SET:  fan_set_reg  <= reg_wdata[TEMP_BITS-1:0];
            ADDR_IDENT:    ident_reg    <= reg_wdata[PORTS-1:0];
            ADDR_IRQ_MASK: irq_mask_reg <= reg_wdata[IRQ_BITS-1:0];
            default: ;
         endcase
      end
   end

   // set wins over a simultaneous write-one clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq_status_reg <= '0;
      end else if (clk_en) begin
         if (reg_write && reg_addr == ADDR_IRQ_STATUS) begin
            irq_status_reg <= (irq_status_reg & ~reg_wdata[IRQ_BITS-1:0]) | irq_events;
         end else begin
            irq_status_reg <= irq_status_reg | irq_events;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reg_rdata <= '0;
      end else if (clk_en) begin
         // read data stand one cycle only, so a stale word is never taken twice
         reg_rdata <= '0;
         if (reg_read) begin
            unique case (reg_addr)
               ADDR_CTRL:       reg_rdata <= {24'h000000, ctrl_reg};
               ADDR_FAN_SET:    reg_rdata <= 32'(fan_set_reg);
               ADDR_TEMP:       reg_rdata <= 32'(s_temp);
               ADDR_IDENT:      reg_rdata <= 32'(ident_reg);
               ADDR_IRQ_STATUS: reg_rdata <= 32'(irq_status_reg);
               ADDR_IRQ_MASK:   reg_rdata <= 32'(irq_mask_reg);
               ADDR_SNAPSHOT:   reg_rdata <= image;
               default:         reg_rdata <= '0;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

//--- bench/nss_scan_chain_sva.sv
`timescale 1ns/10ps
`default_nettype none
module nss_scan_chain_sva
   import nss_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // scan link
   input wire logic        scan_clk,
   input wire logic        capture_strobe_n,
   input wire logic        scan_data_out,
   input wire logic [3:0]  card_presence_straps_n,
   // register port and interrupt
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [3:0] sclk_h;
   logic [3:0] ld_h;
   logic [3:0] mask_sh;
   wire        cause;
   // any scan rise or load seen in the last few samples may move the output
   assign cause = (|(sclk_h[2:0] & ~sclk_h[3:1])) | (|ld_h);
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         sclk_h <= 4'h0;
         ld_h   <= 4'h0;
      end else begin
         sclk_h <= {sclk_h[2:0], scan_clk};
         ld_h   <= {ld_h[2:0], ~capture_strobe_n};
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n)
         mask_sh <= 4'h0;
      else if (reg_write && reg_addr == ADDR_IRQ_MASK)
         mask_sh <= reg_wdata[3:0];
   end
   a_out_reset_idle: assert property ($rose(reset_n) |-> scan_data_out)
      else $error("scan output not idle high after reset");
   a_irq_reset_low: assert property ($rose(reset_n) |-> !irq)
      else $error("irq high after reset");
   a_rdata_one_cycle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_unmapped_zero: assert property (reg_read && reg_addr > 4'h6 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_narrow_fields: assert property (reg_read && reg_addr < 4'h3 |=> reg_rdata[31:8] == 24'h0)
      else $error("narrow register has high bits");
   a_load_shows_bit0: assert property ((!capture_strobe_n && $stable(card_presence_straps_n))[*6]
      |-> scan_data_out == card_presence_straps_n[0])
      else $error("loaded chain does not show strap bit 0");
   a_shift_needs_cause: assert property ($changed(scan_data_out) |-> cause)
      else $error("scan output moved without a shift or load");
   a_irq_masked_off: assert property ((mask_sh == 4'h0)[*2] |-> !irq)
      else $error("irq high with all sources masked");
   c_load: cover property ((!capture_strobe_n)[*6]);
   c_irq: cover property (irq);
   c_unmapped: cover property (reg_read && reg_addr > 4'h6);
endmodule
bind nss_scan_chain nss_scan_chain_sva nss_scan_chain_sva_inst (.clk(clk), .reset_n(reset_n),
   .scan_clk(scan_clk), .capture_strobe_n(capture_strobe_n), .scan_data_out(scan_data_out),
   .card_presence_straps_n(card_presence_straps_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire

//--- bench/nss_scan_host.sv
`timescale 1ns/10ps
`default_nettype none
module nss_scan_host (
   // link toward the card
   output var logic scan_clk,
   output var logic capture_strobe_n,
   input wire logic scan_data_out
);
   // both lines idle high as the pull-ups leave them
   initial begin
      scan_clk = 1'b1;
      capture_strobe_n = 1'b1;
   end
   // 800 ns period keeps well below the top scan rate
   task automatic frame(output logic [39:0] w);
      #7 capture_strobe_n = 1'b0;
      #800 capture_strobe_n = 1'b1;
      #400;
      for (int i = 0; i < 40; i++) begin
         scan_clk = 1'b0;
         #400 w[i] = scan_data_out;
         scan_clk = 1'b1;
         #400;
      end
   endtask
   // accept a stream only once two frames in a row agree
   task automatic read_status(output logic [39:0] w, output logic ok);
      logic [39:0] a;
      logic [39:0] b;
      ok = 1'b0;
      frame(a);
      for (int t = 0; t < 4 && !ok; t++) begin
         frame(b);
         ok = (a === b);
         a = b;
      end
      w = a;
   endtask
endmodule
`default_nettype wire

//--- bench/test_nss_scan_chain.sv
`timescale 1ns/10ps
`default_nettype none
module test_nss_scan_chain;
   import nss_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        scan_clk, capture_strobe_n, scan_data_out, irq, ok;
   logic [3:0]  straps = 4'ha;
   logic        wake_n = 1'b1, warn = 1'b0, crit = 1'b0;
   logic [7:0]  temp = 8'h14, up = 8'h0, maxs = 8'h0, trf = 8'h0;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic        reg_write = 1'b0, reg_read = 1'b0, clk_en = 1'b1;
   logic [39:0] w;
   logic [1:0]  lo = 2'h0, hi = 2'h0;
   int          error_cnt = 0, n_compared = 0;
   always #50 clk = ~clk;
   nss_scan_chain #(.BLINK_CYCLES(1000)) nss_scan_chain_inst (.clk(clk), .reset_n(reset_n),
      .clk_en(clk_en), .scan_clk(scan_clk), .capture_strobe_n(capture_strobe_n),
      .scan_data_out(scan_data_out), .card_presence_straps_n(straps), .wake_n(wake_n),
      .temp_warn_any(warn), .thermal_critical_any(crit), .fan_temp(temp), .port_link_up(up),
      .port_at_max_speed(maxs), .port_traffic(trf), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));
   nss_scan_host nss_scan_host_inst (.scan_clk(scan_clk), .capture_strobe_n(capture_strobe_n),
      .scan_data_out(scan_data_out));
   // image of a quiet card: no port carries traffic
   function automatic logic [39:0] expect_img(input logic fan);
      logic [39:0] e;
      e = {8'hff, 24'h0, fan, ~crit, ~warn, wake_n, straps};
      for (int p = 0; p < 8; p++) begin
         e[8+3*p +: 3] = {~up[p], ~(up[p] & ~maxs[p]), ~(up[p] & maxs[p])};
      end
      return e;
   endfunction
   task chk(input logic [39:0] got, input logic [39:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      v = reg_rdata;
   endtask
   task scan(input logic fan);
      nss_scan_host_inst.read_status(w, ok);
      chk(40'(ok), 40'h1);
      chk(w, expect_img(fan));
      @(posedge clk);
   endtask
   task give_verdict;
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #5_000_000;
      error_cnt++;
      give_verdict;
   end
   initial begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      rd(ADDR_FAN_SET, d);
      chk(40'(d), 40'(FAN_SET_RESET));
      wr(ADDR_CTRL, 32'h1a5);
      rd(ADDR_CTRL, d);
      chk(40'(d), 40'ha5);
      rd(4'hf, d);
      chk(40'(d), 40'h0);
      // a write while the clock enable is low must leave the register alone
      @(posedge clk);
      clk_en <= 1'b0;
      wr(ADDR_CTRL, 32'h3c);
      clk_en <= 1'b1;
      rd(ADDR_CTRL, d);
      chk(40'(d), 40'ha5);
      scan(1'b0);
      rd(ADDR_SNAPSHOT, d);
      chk({8'hff, d}, expect_img(1'b0));
      rd(ADDR_TEMP, d);
      chk(40'(d), 40'h14);
      @(posedge clk);
      {straps, wake_n, warn, crit} <= {4'h5, 3'b011};
      {up, maxs, temp} <= {8'h55, 8'h11, 8'h56};
      scan(1'b1);
      temp <= 8'h51;
      scan(1'b1);
      temp <= 8'h50;
      scan(1'b0);
      rd(ADDR_IRQ_STATUS, d);
      chk(40'(d), 40'hf);
      chk(40'(irq), 40'h0);
      wr(ADDR_IRQ_MASK, 32'h1);
      repeat (3) @(negedge clk);
      chk(40'(irq), 40'h1);
      wr(ADDR_IRQ_STATUS, 32'hf);
      rd(ADDR_IRQ_STATUS, d);
      chk({39'h0, irq}, 40'h0);
      chk(40'(d), 40'h0);
      // traffic on port 3 and identify blink on port 1
      @(posedge clk);
      up <= 8'h5d;
      trf <= 8'h08;
      wr(ADDR_IDENT, 32'h2);
      for (int i = 0; i < 16; i++) begin
         nss_scan_host_inst.frame(w);
         lo = lo | ~{w[19], w[11]};
         hi = hi | {w[19], w[11]};
      end
      chk(40'({lo, hi}), 40'hf);
      give_verdict;
   end
endmodule
`default_nettype wire
